// ==== pmw_bank.sv ====
// Purpose: Warning thresholds, sticky status flags and alert for a hot-swap monitor
// Assumes: Framed PMBus transactions and measurement strobes on the core clock
// Notes: A set in the same cycle as clear faults wins over the clear
`timescale 1ns/10ps

module pmw_bank (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Framed PMBus transaction and its answer
  input wire pmw_pkg::pmw_cmd_s i_cmd,
  output pmw_pkg::pmw_rsp_s o_rsp,
  // Telemetry and core conditions
  input wire pmw_pkg::pmw_meas_s i_meas,
  input wire pmw_pkg::pmw_cond_s i_cond,
  // Alert pin, open drain
  output logic o_smba_o,
  output logic o_smba_oe
);
  import pmw_pkg::*;

  // ***********************************************
  // Helpers
  // ***********************************************
  // Live high limit: enabled and measurement strictly above it
  function automatic logic above_limit(input logic [11:0] meas, input logic [11:0] thr);
    above_limit = (thr != HIGH_LIMIT_OFF) && (meas > thr);
  endfunction : above_limit

  // ***********************************************
  // Declarations
  // ***********************************************
  logic [11:0] ot_thr_q;
  logic [11:0] ov_thr_q;
  logic [11:0] uv_thr_q;
  logic otw_cond_q;
  logic ovw_cond_q;
  logic uvw_cond_q;
  logic uvlo_seen_q;
  logic f_other_q;
  logic f_cml_q;
  logic f_temp_q;
  logic f_vin_uv_q;
  logic f_off_q;
  logic f_pgood_q;
  logic f_mfr_q;
  logic f_input_q;
  logic f_vout_q;
  logic f_vout_uvw_q;
  logic wr_word;
  logic clr;
  logic first_uvlo;
  logic any_alert_evt;
  logic [15:0] status_word;
  logic [7:0] vout_status;

  // Decoded strobes of the command port and the lockout onset
  assign wr_word = i_cmd.valid && (i_cmd.kind == KIND_WRITE_WORD);
  assign clr = i_cmd.valid && (i_cmd.kind == KIND_SEND_BYTE) && (i_cmd.code == CMD_CLEAR_FAULTS);
  assign first_uvlo = i_cond.uvlo_ok && !uvlo_seen_q;

  // ***********************************************
  // Threshold registers
  // ***********************************************
  // Host writes store the 12-bit code; upper bits read zero
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ot_thr_q <= OT_WARN_RESET;
      ov_thr_q <= OV_WARN_RESET;
      uv_thr_q <= UV_WARN_RESET;
    end else if (wr_word) begin
      if (i_cmd.code == CMD_OT_WARN_THR) ot_thr_q <= i_cmd.wdata[11:0];
      if (i_cmd.code == CMD_VIN_OV_WARN_THR) ov_thr_q <= i_cmd.wdata[11:0];
      if (i_cmd.code == CMD_VIN_UV_WARN_THR) uv_thr_q <= i_cmd.wdata[11:0];
    end
  end

  // ***********************************************
  // Limit comparisons
  // ***********************************************
  // Conditions refresh only on a new sample and hold between samples
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ovw_cond_q <= 1'b0;
      uvw_cond_q <= 1'b0;
      otw_cond_q <= 1'b0;
    end else begin
      if (i_meas.vin_upd) begin
        ovw_cond_q <= above_limit(i_meas.vin, ov_thr_q);
        uvw_cond_q <= (uv_thr_q != LOW_LIMIT_OFF) && (i_meas.vin < uv_thr_q);
      end
      if (i_meas.temp_upd) begin
        otw_cond_q <= above_limit(i_meas.temp, ot_thr_q);
      end
    end
  end

  // Remembers that the input has once passed the lockout level
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      uvlo_seen_q <= 1'b0;
    end else if (i_cond.uvlo_ok) begin
      uvlo_seen_q <= 1'b1;
    end
  end

  // ***********************************************
  // Status flags, sticky except the off bit
  // ***********************************************
  // A set in the same cycle as clear faults wins, so a live condition keeps its flag
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      f_vin_uv_q <= 1'b1;
      f_temp_q <= 1'b0;
      f_cml_q <= 1'b0;
      f_other_q <= 1'b1;
      f_vout_q <= 1'b0;
      f_input_q <= 1'b1;
      f_mfr_q <= 1'b1;
      f_pgood_q <= 1'b1;
      f_vout_uvw_q <= 1'b0;
    end else begin
      f_vin_uv_q <= (f_vin_uv_q && !clr && !first_uvlo) || uvw_cond_q || i_cond.vin_uv_fault;
      f_temp_q <= (f_temp_q && !clr) || otw_cond_q || i_cond.ot_fault;
      f_cml_q <= (f_cml_q && !clr) || i_cond.cml_fault;
      f_other_q <= (f_other_q && !clr) || ovw_cond_q || i_cond.vout_uv_warn || i_cond.mfr_event
                   || !i_cond.pgood || i_cond.input_fault;
      f_vout_q <= (f_vout_q && !clr) || i_cond.vout_uv_warn;
      f_input_q <= (f_input_q && !clr && !first_uvlo) || ovw_cond_q || uvw_cond_q
                   || i_cond.input_fault || i_cond.vin_uv_fault;
      f_mfr_q <= (f_mfr_q && !clr) || i_cond.mfr_event;
      f_pgood_q <= (f_pgood_q && !clr) || !i_cond.pgood;
      f_vout_uvw_q <= (f_vout_uvw_q && !clr) || i_cond.vout_uv_warn;
    end
  end

  // Off bit follows the pass switch, one from reset
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      f_off_q <= 1'b1;
    end else begin
      f_off_q <= !i_cond.switch_on;
    end
  end

  // ***********************************************
  // Status assembly
  // ***********************************************
  // Unsupported positions are tied to zero
  always_comb begin
    status_word = 16'h0000;
    status_word[BIT_OTHER] = f_other_q;
    status_word[BIT_CML] = f_cml_q;
    status_word[BIT_TEMP] = f_temp_q;
    status_word[BIT_VIN_UV] = f_vin_uv_q;
    status_word[BIT_OFF] = f_off_q;
    status_word[BIT_PGOOD] = f_pgood_q;
    status_word[BIT_MFR] = f_mfr_q;
    status_word[BIT_INPUT] = f_input_q;
    status_word[BIT_VOUT] = f_vout_q;
    vout_status = 8'h00;
    vout_status[BIT_VOUT_UV_WARN] = f_vout_uvw_q;
  end

  // ***********************************************
  // Alert pin
  // ***********************************************
  assign any_alert_evt = ovw_cond_q || uvw_cond_q || otw_cond_q || i_cond.vout_uv_warn || i_cond.vin_uv_fault
                         || i_cond.ot_fault || i_cond.cml_fault || i_cond.mfr_event || i_cond.input_fault;

  // Pulls the line low until clear faults; a live condition other than power-good low re-asserts at once
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_smba_oe <= 1'b0;
      o_smba_o <= 1'b0;
    end else begin
      o_smba_oe <= (o_smba_oe && !clr) || any_alert_evt;
      o_smba_o <= 1'b0;
    end
  end

  // ***********************************************
  // Transaction answers
  // ***********************************************
  // One cycle after each command; unknown code or wrong protocol flags an error
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rsp <= '0;
    end else begin
      o_rsp.valid <= i_cmd.valid;
      o_rsp.err <= 1'b0;
      o_rsp.two_bytes <= 1'b0;
      o_rsp.data <= 16'h0000;
      if (i_cmd.valid) begin
        unique case (i_cmd.kind)
          KIND_SEND_BYTE: begin
            o_rsp.err <= !clr;
          end
          KIND_READ_BYTE: begin
            if (i_cmd.code == CMD_SUMMARY_BYTE) begin
              o_rsp.data <= {8'h00, status_word[7:0]};
            end else if (i_cmd.code == CMD_VOUT_STATUS) begin
              o_rsp.data <= {8'h00, vout_status};
            end else begin
              o_rsp.err <= 1'b1;
            end
          end
          KIND_READ_WORD: begin
            o_rsp.two_bytes <= 1'b1;
            if (i_cmd.code == CMD_OT_WARN_THR) begin
              o_rsp.data <= {4'h0, ot_thr_q};
            end else if (i_cmd.code == CMD_VIN_OV_WARN_THR) begin
              o_rsp.data <= {4'h0, ov_thr_q};
            end else if (i_cmd.code == CMD_VIN_UV_WARN_THR) begin
              o_rsp.data <= {4'h0, uv_thr_q};
            end else if (i_cmd.code == CMD_SUMMARY_WORD) begin
              o_rsp.data <= status_word;
            end else begin
              o_rsp.err <= 1'b1;
            end
          end
          KIND_WRITE_WORD: begin
            o_rsp.err <= !((i_cmd.code == CMD_OT_WARN_THR) || (i_cmd.code == CMD_VIN_OV_WARN_THR)
                           || (i_cmd.code == CMD_VIN_UV_WARN_THR));
          end
        endcase
      end
    end
  end

  // ***********************************************
  // Checks
  // ***********************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_clear_cmd;
    clr;
  endsequence

  sequence s_quiet;
    !any_alert_evt;
  endsequence

  chk_ot_disabled: assert property ((i_meas.temp_upd && ot_thr_q == HIGH_LIMIT_OFF) |=> !otw_cond_q)
    else $error("temperature warn raised with limit disabled");
  chk_ov_sets: assert property ((i_meas.vin_upd && ov_thr_q != HIGH_LIMIT_OFF && i_meas.vin > ov_thr_q)
    |=> ##1 (f_input_q && f_other_q && o_smba_oe))
    else $error("over-voltage crossing missed");
  chk_uv_sets: assert property ((i_meas.vin_upd && uv_thr_q != LOW_LIMIT_OFF && i_meas.vin < uv_thr_q)
    |=> ##1 (f_vin_uv_q && o_smba_oe))
    else $error("under-voltage crossing missed");
  chk_ot_sets: assert property ((i_meas.temp_upd && ot_thr_q != HIGH_LIMIT_OFF && i_meas.temp > ot_thr_q)
    |=> ##1 (f_temp_q && o_smba_oe))
    else $error("over-temperature crossing missed");
  chk_vout_uv_sets: assert property (i_cond.vout_uv_warn |=> (f_vout_uvw_q && f_vout_q && o_smba_oe))
    else $error("output under-voltage warn not recorded");
  chk_input_sets: assert property ((i_cond.input_fault || i_cond.vin_uv_fault) |=> f_input_q)
    else $error("input summary flag not set");
  chk_other_sets: assert property ((i_cond.mfr_event || !i_cond.pgood || i_cond.input_fault) |=> f_other_q)
    else $error("other-event flag not set");
  chk_uv_disabled: assert property ((i_meas.vin_upd && uv_thr_q == LOW_LIMIT_OFF) |=> !uvw_cond_q)
    else $error("under-voltage warn raised with limit disabled");
  chk_flag_holds: assert property ((otw_cond_q ##0 s_clear_cmd) |=> f_temp_q)
    else $error("temperature flag lost while condition present");
  chk_byte_answer: assert property (
    (i_cmd.valid && i_cmd.kind == KIND_READ_BYTE && i_cmd.code == CMD_SUMMARY_BYTE)
    |=> (o_rsp.valid && !o_rsp.two_bytes && o_rsp.data[15:8] == 8'h00))
    else $error("status byte read not answered with one byte");
  chk_off_bit: assert property (!i_cond.switch_on |=> status_word[BIT_OFF])
    else $error("off bit clear with switch off");
  chk_unsup_zero: assert property (((status_word & WORD_UNSUP_MASK) == 16'h0000)
    && ((vout_status & 8'hdf) == 8'h00))
    else $error("unsupported status bit set");
  chk_word_low: assert property (
    (i_cmd.valid && i_cmd.kind == KIND_READ_WORD && i_cmd.code == CMD_SUMMARY_WORD)
    |=> (o_rsp.two_bytes && o_rsp.data[7:0] == $past(status_word[7:0])))
    else $error("status word low byte differs");
  chk_uvlo_clear: assert property ((first_uvlo && !uvw_cond_q && !ovw_cond_q && !i_cond.input_fault
    && !i_cond.vin_uv_fault) |=> (!f_input_q && !f_vin_uv_q))
    else $error("input flags not cleared at first lockout crossing");
  chk_clear_release: assert property ((s_clear_cmd ##0 s_quiet) |=> !o_smba_oe)
    else $error("alert not released by clear faults");

endmodule : pmw_bank

// ==== pmw_pkg.sv ====
// Purpose: Shared constants and carriers for the warning-limit and status bank
// Assumes: 12-bit telemetry codes, commands already framed by the SMBus engine
// Notes: Command codes are the PMBus command bytes of this bank

package pmw_pkg;

  // ***********************************************
  // Command codes
  // ***********************************************
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_OT_WARN_THR = 8'h51;
  localparam logic [7:0] CMD_VIN_OV_WARN_THR = 8'h57;
  localparam logic [7:0] CMD_VIN_UV_WARN_THR = 8'h58;
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
  localparam logic [7:0] CMD_VOUT_STATUS = 8'h7a;

  // ***********************************************
  // Threshold values after reset and disable codes
  // ***********************************************
  localparam logic [11:0] OT_WARN_RESET = 12'h07d0;
  localparam logic [11:0] OV_WARN_RESET = 12'h0fff;
  localparam logic [11:0] UV_WARN_RESET = 12'h0000;
  localparam logic [11:0] HIGH_LIMIT_OFF = 12'h0fff;
  localparam logic [11:0] LOW_LIMIT_OFF = 12'h0000;

  // ***********************************************
  // Status field positions
  // ***********************************************
  localparam int BIT_OTHER = 0;
  localparam int BIT_CML = 1;
  localparam int BIT_TEMP = 2;
  localparam int BIT_VIN_UV = 3;
  localparam int BIT_OFF = 6;
  localparam int BIT_PGOOD = 11;
  localparam int BIT_MFR = 12;
  localparam int BIT_INPUT = 13;
  localparam int BIT_VOUT = 15;
  localparam int BIT_VOUT_UV_WARN = 5;
  localparam logic [15:0] WORD_UNSUP_MASK = 16'h47b0;

  // ***********************************************
  // Temperature detection time of the averaged front end
  // ***********************************************
  localparam int OT_DETECT_MS = 16;
  localparam int MCLK_HZ = 10_000_000;
  localparam int OT_DETECT_CYC = OT_DETECT_MS * (MCLK_HZ / 1000);

  // ***********************************************
  // Transaction kinds and carriers
  // ***********************************************
  typedef enum logic [1:0] {
    KIND_SEND_BYTE = 2'b00,
    KIND_READ_BYTE = 2'b01,
    KIND_READ_WORD = 2'b10,
    KIND_WRITE_WORD = 2'b11
  } pmw_kind_e;

  typedef struct packed {
    logic valid;
    pmw_kind_e kind;
    logic [7:0] code;
    logic [15:0] wdata;
  } pmw_cmd_s;

  typedef struct packed {
    logic valid;
    logic err;
    logic two_bytes;
    logic [15:0] data;
  } pmw_rsp_s;

  typedef struct packed {
    logic vin_upd;
    logic [11:0] vin;
    logic temp_upd;
    logic [11:0] temp;
  } pmw_meas_s;

  typedef struct packed {
    logic switch_on;
    logic pgood;
    logic uvlo_ok;
    logic vout_uv_warn;
    logic vin_uv_fault;
    logic ot_fault;
    logic cml_fault;
    logic mfr_event;
    logic input_fault;
  } pmw_cond_s;

endpackage : pmw_pkg

// ==== pmw_host.sv ====
// Purpose: Host model issuing framed PMBus transactions to the bank
// Assumes: One transaction in flight, answer one cycle after the taking edge
// Notes: Idle request fields carry the inverse of the last request
`timescale 1ns/10ps

module pmw_host (
  // Clock
  input wire logic i_mclk,
  // Request and answer
  output pmw_pkg::pmw_cmd_s o_cmd,
  input wire pmw_pkg::pmw_rsp_s i_rsp
);
  import pmw_pkg::*;

  // Idle request at time zero
  initial begin
    o_cmd = '0;
  end

  // Issue one transaction, hold it for its taking edge, catch the answer
  task automatic xfer(input pmw_kind_e kind, input logic [7:0] code, input logic [15:0] wdata,
                      output pmw_rsp_s rsp, output bit late);
    int n;
    late = 1'b1;
    rsp = '0;
    @(posedge i_mclk);
    #1;
    o_cmd = '{valid: 1'b1, kind: kind, code: code, wdata: wdata};
    @(posedge i_mclk);
    #1;
    o_cmd = '{valid: 1'b0, kind: pmw_kind_e'(~kind), code: ~code, wdata: ~wdata};
    // The answer stands only in the cycle right after the taking edge
    for (n = 0; n < 4 && late; n++) begin
      if (i_rsp.valid === 1'b1) begin
        rsp = i_rsp;
        late = 1'b0;
      end else begin
        @(posedge i_mclk);
        #1;
      end
    end
  endtask : xfer

endmodule : pmw_host

// ==== test_pmw_bank.sv ====
// Purpose: Self-checking bench for the warning-limit and status bank
// Assumes: Host model drives transactions, bench drives telemetry and core levels
// Notes: Table rows first, then a second reset and the hand-written cases
`timescale 1ns/10ps

module test_pmw_bank;
  import pmw_pkg::*;

  typedef struct {
    pmw_kind_e kind;
    logic [7:0] code;
    logic [15:0] wdata;
    logic err;
    logic [15:0] data;
  } pmw_row_s;

  logic i_mclk;
  logic i_rstn;
  pmw_cmd_s cmd;
  pmw_rsp_s rsp;
  pmw_meas_s meas;
  pmw_cond_s cond;
  logic smba_o;
  logic smba_oe;
  int miscompares;
  int num_checks;
  int k;
  logic [7:0] dcode[3] = '{CMD_OT_WARN_THR, CMD_VIN_OV_WARN_THR, CMD_VIN_UV_WARN_THR};
  logic [11:0] dval[3] = '{12'h0fff, 12'h0fff, 12'h0000};

  // Transactions beside their expected answers
  pmw_row_s rows[14] = '{
    '{KIND_READ_WORD, CMD_VIN_OV_WARN_THR, 16'h0000, 1'b0, 16'h0fff},
    '{KIND_READ_WORD, CMD_VIN_UV_WARN_THR, 16'h0000, 1'b0, 16'h0000},
    '{KIND_READ_WORD, CMD_OT_WARN_THR, 16'h0000, 1'b0, 16'h07d0},
    '{KIND_READ_BYTE, CMD_SUMMARY_BYTE, 16'h0000, 1'b0, 16'h0049},
    '{KIND_READ_WORD, CMD_SUMMARY_WORD, 16'h0000, 1'b0, 16'h3849},
    '{KIND_READ_BYTE, CMD_VOUT_STATUS, 16'h0000, 1'b0, 16'h0000},
    '{KIND_WRITE_WORD, CMD_VIN_OV_WARN_THR, 16'hf800, 1'b0, 16'h0000},
    '{KIND_READ_WORD, CMD_VIN_OV_WARN_THR, 16'h0000, 1'b0, 16'h0800},
    '{KIND_WRITE_WORD, CMD_VIN_UV_WARN_THR, 16'h0fff, 1'b0, 16'h0000},
    '{KIND_READ_WORD, CMD_VIN_UV_WARN_THR, 16'h0000, 1'b0, 16'h0fff},
    '{KIND_WRITE_WORD, CMD_OT_WARN_THR, 16'h0ffe, 1'b0, 16'h0000},
    '{KIND_READ_WORD, CMD_OT_WARN_THR, 16'h0000, 1'b0, 16'h0ffe},
    '{KIND_WRITE_WORD, CMD_SUMMARY_WORD, 16'h0000, 1'b1, 16'h0000},
    '{KIND_READ_BYTE, CMD_VIN_OV_WARN_THR, 16'h0000, 1'b1, 16'h0000}
  };

  pmw_bank pmw_bank_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_cmd(cmd), .o_rsp(rsp), .i_meas(meas),
    .i_cond(cond), .o_smba_o(smba_o), .o_smba_oe(smba_oe));
  pmw_host pmw_host_i (.i_mclk(i_mclk), .o_cmd(cmd), .i_rsp(rsp));

  // Core clock, 100 ns period
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  // One transaction, its answer checked
  task automatic run(input pmw_kind_e kind, input logic [7:0] code, input logic [15:0] wdata,
                     input logic err, input logic [15:0] data);
    pmw_rsp_s r;
    bit late;
    pmw_host_i.xfer(kind, code, wdata, r, late);
    if (late) begin
      miscompares++;
      conclude();
    end else begin
      cmp_bit("answer error", err, r.err);
      cmp_val("answer data", data, r.data);
      if (!err && kind[1] ^ kind[0]) cmp_bit("answer width", kind[1], r.two_bytes);
    end
  endtask : run

  // One measurement update, flags settled on return
  task automatic upd(input bit tmp, input logic [11:0] v);
    if (tmp) begin
      meas.temp_upd = 1'b1;
      meas.temp = v;
    end else begin
      meas.vin_upd = 1'b1;
      meas.vin = v;
    end
    @(posedge i_mclk);
    #1;
    meas.temp_upd = 1'b0;
    meas.vin_upd = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask : upd

  task automatic stat(input logic [15:0] exp);
    run(KIND_READ_WORD, CMD_SUMMARY_WORD, 16'h0000, 1'b0, exp);
  endtask : stat

  task automatic clr();
    run(KIND_SEND_BYTE, CMD_CLEAR_FAULTS, 16'h0000, 1'b0, 16'h0000);
  endtask : clr

  // Main sequence
  initial begin
    i_rstn = 1'b0;
    meas = '0;
    cond = '0;
    miscompares = 0;
    num_checks = 0;
    repeat (3) @(posedge i_mclk);
    #1;
    i_rstn = 1'b1;
    for (k = 0; k < 14; k++) begin
      run(rows[k].kind, rows[k].code, rows[k].wdata, rows[k].err, rows[k].data);
    end
    $display("test table done");
    i_rstn = 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
    i_rstn = 1'b1;
    run(KIND_READ_WORD, CMD_VIN_OV_WARN_THR, 16'h0000, 1'b0, 16'h0fff);
    cond.switch_on = 1'b1;
    cond.pgood = 1'b1;
    cond.uvlo_ok = 1'b1;
    repeat (3) @(posedge i_mclk);
    #1;
    stat(16'h1801);
    cmp_bit("alert data pin", 1'b0, smba_o);
    clr();
    stat(16'h0000);
    $display("test startup done");
    run(KIND_WRITE_WORD, CMD_VIN_OV_WARN_THR, 16'h0800, 1'b0, 16'h0000);
    run(KIND_WRITE_WORD, CMD_VIN_UV_WARN_THR, 16'h0100, 1'b0, 16'h0000);
    upd(1'b0, 12'h800);
    cmp_bit("alert", 1'b0, smba_oe);
    upd(1'b0, 12'h900);
    cmp_bit("alert", 1'b1, smba_oe);
    stat(16'h2001);
    clr();
    cmp_bit("alert", 1'b1, smba_oe);
    upd(1'b0, 12'h500);
    stat(16'h2001);
    clr();
    cmp_bit("alert", 1'b0, smba_oe);
    upd(1'b0, 12'h0ff);
    cmp_bit("alert", 1'b1, smba_oe);
    run(KIND_READ_BYTE, CMD_SUMMARY_BYTE, 16'h0000, 1'b0, 16'h0008);
    upd(1'b0, 12'h500);
    clr();
    stat(16'h0000);
    $display("test input limits done");
    upd(1'b1, 12'hfff);
    cmp_bit("alert", 1'b1, smba_oe);
    stat(16'h0004);
    clr();
    stat(16'h0004);
    upd(1'b1, 12'h000);
    clr();
    for (k = 0; k < 3; k++) begin
      run(KIND_WRITE_WORD, dcode[k], {4'h0, dval[k]}, 1'b0, 16'h0000);
      upd(k == 0, dval[k]);
      cmp_bit("alert", 1'b0, smba_oe);
    end
    stat(16'h0000);
    $display("test temperature and disabled limits done");
    cond.vout_uv_warn = 1'b1;
    @(posedge i_mclk);
    #1;
    cond.vout_uv_warn = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    cmp_bit("alert", 1'b1, smba_oe);
    run(KIND_READ_BYTE, CMD_VOUT_STATUS, 16'h0000, 1'b0, 16'h0020);
    stat(16'h8001);
    clr();
    run(KIND_READ_BYTE, CMD_VOUT_STATUS, 16'h0000, 1'b0, 16'h0000);
    $display("test output status done");
    cond.cml_fault = 1'b1;
    cond.mfr_event = 1'b1;
    cond.pgood = 1'b0;
    @(posedge i_mclk);
    #1;
    cond.cml_fault = 1'b0;
    cond.mfr_event = 1'b0;
    cond.pgood = 1'b1;
    repeat (2) @(posedge i_mclk);
    #1;
    cmp_bit("alert", 1'b1, smba_oe);
    stat(16'h1803);
    clr();
    cond.input_fault = 1'b1;
    cond.vin_uv_fault = 1'b1;
    cond.ot_fault = 1'b1;
    cond.switch_on = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    stat(16'h204d);
    cond.input_fault = 1'b0;
    cond.vin_uv_fault = 1'b0;
    cond.ot_fault = 1'b0;
    cond.switch_on = 1'b1;
    clr();
    stat(16'h0000);
    cmp_bit("alert", 1'b0, smba_oe);
    $display("test core conditions done");
    conclude();
  end

endmodule : test_pmw_bank
